// File: bench/bus_node_model.sv
`timescale 1ns/1ps
// ************************************
// far side: other nodes and wire faults
// ************************************
module bus_node_model (
    input  wire logic                     node_dom,
    input  wire logic [3:0]               fault,
    input  wire can_fault_pkg::path_sel_t path,
    output can_fault_pkg::bus_comp_t      comp
);
    logic dom;

    // wire levels from all drivers and the injected fault
    always_comb
    begin
        dom            = node_dom || path.drive_h || path.drive_l;
        comp           = '0;
        comp.canh_dom  = (dom && fault != can_fault_pkg::FT_I && fault != can_fault_pkg::FT_V)
                         || fault == can_fault_pkg::FT_VIII;
        comp.canl_dom  = (dom && fault != can_fault_pkg::FT_II && fault != can_fault_pkg::FT_IX)
                         || fault == can_fault_pkg::FT_IV;
        comp.canh_ov   = fault == can_fault_pkg::FT_III;
        comp.canl_ov   = fault == can_fault_pkg::FT_VI;
        comp.canl_low  = fault == can_fault_pkg::FT_IV;
        comp.canh_high = fault == can_fault_pkg::FT_VIII;
        comp.diff_neg  = fault inside {can_fault_pkg::FT_IV, can_fault_pkg::FT_VII,
                                       can_fault_pkg::FT_VIII};
    end
endmodule : bus_node_model

// File: bench/can_bus_fault_manager_bench.sv
`timescale 1ns/1ps
// ************************************
// testbench of the fault manager
// ************************************
module can_bus_fault_manager_bench;
    logic                     clock      = 1'b0;
    logic                     sys_rst    = 1'b1;
    logic                     tx_data_n  = 1'b1;
    logic                     sleep_req  = 1'b0;
    logic                     local_wake = 1'b0;
    logic                     err_clear  = 1'b0;
    logic                     node_dom   = 1'b0;
    logic [3:0]               fault      = 4'h0;
    can_fault_pkg::bus_comp_t comp_in;
    can_fault_pkg::path_sel_t path;
    logic                     rx_data_n, operating, wake_event, err_flag;
    logic [3:0]               err_type;
    int                       mismatches = 0;
    int                       check_count = 0;
    int                       wakes = 0;

    // 100 ns clock
    always #50 clock = ~clock;

    // count wake pulses
    always @(posedge clock)
        if (wake_event === 1'b1)
            wakes++;

    bus_node_model far (.node_dom(node_dom), .fault(fault), .path(path), .comp(comp_in));

    can_bus_fault_manager #(.SHORT_CYCLES(20), .VDD_CYCLES(30), .FAILTX_CYCLES(40)) dut (
        .clock(clock), .sys_rst(sys_rst), .comp_in(comp_in), .tx_data_n(tx_data_n),
        .sleep_req(sleep_req), .local_wake(local_wake), .err_clear(err_clear),
        .rx_data_n(rx_data_n), .path(path), .operating(operating),
        .wake_event(wake_event), .err_flag(err_flag), .err_type(err_type));

    // verdict and end of run
    task complete_run;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run

    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #10;
    endtask : cyc

    // bounded wait on operating (op) or on the error flag
    task automatic wait_on(input bit op, input logic v, input int lim);
        int i;
        i = 0;
        while ((op ? operating : err_flag) !== v && i < lim)
        begin
            cyc(1);
            i++;
        end
        if ((op ? operating : err_flag) !== v)
        begin
            mismatches++;
            $display("ERROR t=%0t wait ran out", $time);
            complete_run();
        end
    endtask : wait_on

    task automatic pulses(input int n);
        repeat (n)
        begin
            @(posedge clock) node_dom <= 1'b1;
            cyc(5);
            @(posedge clock) node_dom <= 1'b0;
            cyc(5);
        end
    endtask : pulses

    task automatic clr_err;
        @(posedge clock) err_clear <= 1'b1;
        wait_on(0, 1'b0, 3000);
        @(posedge clock) err_clear <= 1'b0;
        cyc(2);
        check(err_type, 4'h0);
    endtask : clr_err

    task automatic t_wire_loss;
        @(posedge clock) fault <= can_fault_pkg::FT_I;
        pulses(6);
        wait_on(0, 1'b1, 100);
        check({3'h0, err_type === can_fault_pkg::FT_I || err_type === can_fault_pkg::FT_V},
              4'h1);
        check({3'h0, path.rx_diff}, 4'h1);
        @(posedge clock) tx_data_n <= 1'b0;
        cyc(6);
        check(path & 4'hc, 4'h4);
        @(posedge clock) tx_data_n <= 1'b1;
        @(posedge clock) fault <= 4'h0;
        pulses(4);
        clr_err();
    endtask : t_wire_loss

    task automatic t_ov(input logic [3:0] code, input logic [3:0] idle, input logic [3:0] drv);
        @(posedge clock) fault <= code;
        cyc(200);
        @(posedge clock) fault <= 4'h0;
        cyc(5);
        @(posedge clock) fault <= code;
        cyc(300);
        check({3'h0, err_flag}, 4'h0);
        wait_on(0, 1'b1, 60);
        check(err_type, code);
        check(path, idle);
        @(posedge clock) tx_data_n <= 1'b0;
        cyc(6);
        check(path, drv);
        @(posedge clock) tx_data_n <= 1'b1;
        fault <= 4'h0;
        clr_err();
    endtask : t_ov

    task automatic t_short(input logic [3:0] code, input logic [3:0] drv);
        @(posedge clock) fault <= code;
        wait_on(0, 1'b1, 80);
        check(err_type, code);
        @(posedge clock) tx_data_n <= 1'b0;
        cyc(6);
        check(path & 4'he, drv);
        @(posedge clock) tx_data_n <= 1'b1;
        fault <= 4'h0;
        clr_err();
    endtask : t_short

    task automatic t_failsafe;
        @(posedge clock) tx_data_n <= 1'b0;
        cyc(6);
        check(path & 4'he, 4'he);
        wait_on(0, 1'b1, 80);
        check(err_type, can_fault_pkg::FT_X);
        cyc(10);
        check(path & 4'hc, 4'h0);
        check({3'h0, rx_data_n}, 4'h1);
        @(posedge clock) tx_data_n <= 1'b1;
        cyc(60);
        @(posedge clock) tx_data_n <= 1'b0;
        cyc(6);
        check(path & 4'hc, 4'hc);
        @(posedge clock) tx_data_n <= 1'b1;
        clr_err();
    endtask : t_failsafe

    task automatic t_sleep;
        @(posedge clock) sleep_req <= 1'b1;
        @(posedge clock) sleep_req <= 1'b0;
        wait_on(1, 1'b0, 20);
        @(posedge clock) node_dom <= 1'b1;
        cyc(150);
        @(posedge clock) node_dom <= 1'b0;
        cyc(10);
        check({3'h0, operating}, 4'h0);
        @(posedge clock) node_dom <= 1'b1;
        wait_on(1, 1'b1, 300);
        cyc(20);
        @(posedge clock) node_dom <= 1'b0;
        sleep_req <= 1'b1;
        @(posedge clock) sleep_req <= 1'b0;
        wait_on(1, 1'b0, 20);
        @(posedge clock) local_wake <= 1'b1;
        @(posedge clock) local_wake <= 1'b0;
        wait_on(1, 1'b1, 20);
        cyc(3);
        check(wakes[3:0], 4'h2);
    endtask : t_sleep

    // main sequence
    initial
    begin
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        cyc(2);
        check({operating, wake_event, err_flag, rx_data_n}, 4'h9);
        check(path, 4'h3);
        t_wire_loss();
        t_ov(can_fault_pkg::FT_III, 4'h0, 4'h4);
        t_ov(can_fault_pkg::FT_VI, 4'h1, 4'h9);
        t_short(can_fault_pkg::FT_IV, 4'hc);
        t_short(can_fault_pkg::FT_VII, 4'h8);
        t_short(can_fault_pkg::FT_VIII, 4'hc);
        t_failsafe();
        t_sleep();
        complete_run();
    end
endmodule : can_bus_fault_manager_bench

// File: bench/can_bus_fault_manager_properties.sv
`timescale 1ns/1ps
// ************************************
// port checker of the fault manager
// ************************************
module fault_checker #(
    parameter int SHORT_CYCLES  = 20,
    parameter int VDD_CYCLES    = 20,
    parameter int FAILTX_CYCLES = 20
) (
    input wire logic                     clock,
    input wire logic                     sys_rst,
    input wire can_fault_pkg::bus_comp_t comp_in,
    input wire logic                     tx_data_n,
    input wire logic                     sleep_req,
    input wire logic                     local_wake,
    input wire logic                     err_clear,
    input wire logic                     rx_data_n,
    input wire can_fault_pkg::path_sel_t path,
    input wire logic                     operating,
    input wire logic                     wake_event,
    input wire logic                     err_flag,
    input wire logic [3:0]               err_type
);
    localparam int OV_LATE = 330;
    int hov, lov, txl, dom, both, rec, lw;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    // run lengths of input levels
    always_ff @(posedge clock)
    begin
        hov  <= comp_in.canh_ov ? hov + 1 : 0;
        lov  <= comp_in.canl_ov ? lov + 1 : 0;
        txl  <= !tx_data_n ? txl + 1 : 0;
        dom  <= (comp_in.canh_dom || comp_in.canl_dom) ? dom + 1 : 0;
        both <= (comp_in.canh_dom && comp_in.canl_dom) ? both + 1 : 0;
        rec  <= !(comp_in.canh_dom || comp_in.canl_dom) ? rec + 1 : 0;
    end

    // cycles left in the 8 cycle window after a local wake
    always_ff @(posedge clock)
    begin
        lw  <= local_wake ? 8 : (lw > 0 ? lw - 1 : 0);
    end

    a_ov_high: assert property (
        hov == OV_LATE |-> err_flag && path[1:0] == 2'h0 && !path.drive_h)
        else $error("canh overvoltage path wrong");
    a_ov_low: assert property (
        lov == OV_LATE |-> err_flag && path[1:0] == 2'h1 && !path.drive_l)
        else $error("canl overvoltage path wrong");
    a_ov_early: assert property (
        $rose(err_flag) && err_type == can_fault_pkg::FT_III |-> hov >= 300)
        else $error("overvoltage flagged early");
    a_failsafe_off: assert property (
        txl == FAILTX_CYCLES + 10 |-> !path.drive_h && !path.drive_l)
        else $error("drivers still on after long dominant");
    a_tx_drive: assert property (
        txl == 4 && operating && !err_flag |-> path.drive_h && path.drive_l)
        else $error("dominant request not driven");
    a_rx_dom: assert property (
        both == 5 && operating |-> !rx_data_n)
        else $error("dominant bus not received");
    a_rx_rec: assert property (
        rec == 5 && operating |-> rx_data_n)
        else $error("recessive bus not received");
    a_wake_bus: assert property (
        dom == 240 && !sleep_req |-> operating)
        else $error("no wake on long dominant");
    a_wake_filter: assert property (
        $rose(operating) |-> lw != 0 || dom >= 200)
        else $error("wake without cause");
    a_wake_pulse: assert property (
        wake_event |-> ##[0:2] operating ##1 !wake_event)
        else $error("wake pulse wrong");
    a_type_range: assert property (
        err_flag |-> err_type inside {[4'h1:4'ha]})
        else $error("error type out of range");
    a_record_holds: assert property (
        err_flag && !err_clear |=> err_flag)
        else $error("error record lost without clear");

    cover property (txl == FAILTX_CYCLES + 10);
    cover property (hov == OV_LATE);
    cover property ($rose(operating));
    cover property (err_flag ##1 !err_flag);
endmodule : fault_checker

bind can_bus_fault_manager fault_checker #(
    .SHORT_CYCLES(SHORT_CYCLES),
    .VDD_CYCLES(VDD_CYCLES),
    .FAILTX_CYCLES(FAILTX_CYCLES)
) chk (
    .clock(clock),
    .sys_rst(sys_rst),
    .comp_in(comp_in),
    .tx_data_n(tx_data_n),
    .sleep_req(sleep_req),
    .local_wake(local_wake),
    .err_clear(err_clear),
    .rx_data_n(rx_data_n),
    .path(path),
    .operating(operating),
    .wake_event(wake_event),
    .err_flag(err_flag),
    .err_type(err_type)
);

// File: src/can_bus_fault_manager.sv
`timescale 1ns/1ps
// ************************************************************
// fault supervision and path routing of the bus transceiver
// ************************************************************
module can_bus_fault_manager #(
    parameter int SHORT_CYCLES  = can_fault_pkg::SHORT_CYC,
    parameter int VDD_CYCLES    = can_fault_pkg::VDD_CYC,
    parameter int FAILTX_CYCLES = can_fault_pkg::FAILTX_CYC
) (
    input  wire logic                     clock,
    input  wire logic                     sys_rst,
    input  wire can_fault_pkg::bus_comp_t comp_in,
    input  wire logic                     tx_data_n,
    input  wire logic                     sleep_req,
    input  wire logic                     local_wake,
    input  wire logic                     err_clear,
    output logic                          rx_data_n,
    output can_fault_pkg::path_sel_t      path,
    output logic                          operating,
    output logic                          wake_event,
    output logic                          err_flag,
    output logic [3:0]                    err_type
);
    // ********************************************************
    // input synchronisers
    // ********************************************************
    can_fault_pkg::bus_comp_t comp_meta;
    can_fault_pkg::bus_comp_t comp;
    logic                     tx_meta;
    logic                     tx_n;

    // two flip-flops on every comparator level and on transmit data
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            comp_meta <= '0;
            comp      <= '0;
            tx_meta   <= 1'b1;
            tx_n      <= 1'b1;
        end
        else
        begin
            comp_meta <= comp_in;
            comp      <= comp_meta;
            tx_meta   <= tx_data_n;
            tx_n      <= tx_meta;
        end
    end

    // ********************************************************
    // persistence timers
    // ********************************************************
    logic ov_h;
    logic ov_l;
    logic gnd_l;
    logic wires_short;
    logic vdd_h;
    logic tx_stuck;
    logic wake_dom;

    persist_timer #(.COUNT(can_fault_pkg::OV_CYC)) u_ov_h (
        .clock   (clock),
        .sys_rst (sys_rst),
        .cond    (comp.canh_ov),
        .expired (ov_h)
    );
    persist_timer #(.COUNT(can_fault_pkg::OV_CYC)) u_ov_l (
        .clock   (clock),
        .sys_rst (sys_rst),
        .cond    (comp.canl_ov),
        .expired (ov_l)
    );
    persist_timer #(.COUNT(SHORT_CYCLES)) u_gnd_l (
        .clock   (clock),
        .sys_rst (sys_rst),
        .cond    (comp.canl_low && comp.diff_neg),
        .expired (gnd_l)
    );
    persist_timer #(.COUNT(SHORT_CYCLES)) u_short (
        .clock   (clock),
        .sys_rst (sys_rst),
        .cond    (comp.diff_neg && !comp.canl_low && !comp.canh_high),
        .expired (wires_short)
    );
    persist_timer #(.COUNT(VDD_CYCLES)) u_vdd_h (
        .clock   (clock),
        .sys_rst (sys_rst),
        .cond    (comp.canh_high && comp.diff_neg),
        .expired (vdd_h)
    );
    persist_timer #(.COUNT(FAILTX_CYCLES)) u_tx_stuck (
        .clock   (clock),
        .sys_rst (sys_rst),
        .cond    (operating && !tx_n),
        .expired (tx_stuck)
    );
    persist_timer #(.COUNT(can_fault_pkg::WAKE_CYC)) u_wake (
        .clock   (clock),
        .sys_rst (sys_rst),
        .cond    (!operating && (comp.canh_dom || comp.canl_dom)),
        .expired (wake_dom)
    );

    // ********************************************************
    // edge counting per wire
    // ********************************************************
    logic       h_prev;
    logic       l_prev;
    logic [2:0] h_edges;
    logic [2:0] l_edges;
    logic       h_fall;
    logic       l_fall;
    logic       h_lost;
    logic       l_lost;
    logic [1:0] h_recov;
    logic [1:0] l_recov;

    assign h_fall = h_prev && !comp.canh_dom;
    assign l_fall = l_prev && !comp.canl_dom;

    // saturating increment used on both counters
    function automatic logic [2:0] sat_inc(input logic [2:0] v);
        sat_inc = (v == 3'h7) ? v : v + 3'h1;
    endfunction : sat_inc

    // dominant to recessive edges on each wire; matched edges clear both
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            h_prev  <= 1'b0;
            l_prev  <= 1'b0;
            h_edges <= 3'h0;
            l_edges <= 3'h0;
        end
        else
        begin
            h_prev <= comp.canh_dom;
            l_prev <= comp.canl_dom;
            if ((h_fall && l_fall) || !operating)
            begin
                h_edges <= 3'h0;
                l_edges <= 3'h0;
            end
            else
            begin
                if (h_fall)
                    h_edges <= (l_edges != 3'h0) ? 3'h0 : sat_inc(h_edges);
                if (l_fall)
                    l_edges <= (h_edges != 3'h0) ? 3'h0 : sat_inc(l_edges);
            end
        end
    end

    // loss of a wire latched at difference above limit, cleared by fresh edges
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            h_lost  <= 1'b0;
            l_lost  <= 1'b0;
            h_recov <= 2'h0;
            l_recov <= 2'h0;
        end
        else
        begin
            if (32'(l_edges) > can_fault_pkg::EDGE_LIMIT)
                h_lost <= 1'b1;
            else if (h_lost && h_fall)
            begin
                h_recov <= h_recov + 2'h1;
                if (32'(h_recov) + 1 >= can_fault_pkg::EDGE_RECOV)
                begin
                    h_lost  <= 1'b0;
                    h_recov <= 2'h0;
                end
            end
            if (32'(h_edges) > can_fault_pkg::EDGE_LIMIT)
                l_lost <= 1'b1;
            else if (l_lost && l_fall)
            begin
                l_recov <= l_recov + 2'h1;
                if (32'(l_recov) + 1 >= can_fault_pkg::EDGE_RECOV)
                begin
                    l_lost  <= 1'b0;
                    l_recov <= 2'h0;
                end
            end
        end
    end

    // ********************************************************
    // fail safe and mode control
    // ********************************************************
    logic       tx_block;
    logic [5:0] recov_cnt;

    // stuck transmit blocks drivers until transmit has been recessive for RECOV_CYC cycles in a row
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            tx_block  <= 1'b0;
            recov_cnt <= 6'h0;
        end
        else if (tx_stuck)
        begin
            tx_block  <= 1'b1;
            recov_cnt <= 6'h0;
        end
        else if (tx_block && tx_n)
        begin
            recov_cnt <= recov_cnt + 6'h1;
            if (32'(recov_cnt) + 1 >= can_fault_pkg::RECOV_CYC)
                tx_block <= 1'b0;
        end
        else
            recov_cnt <= 6'h0;
    end

    // sleep entered on request, left on local or bus wake
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            operating  <= 1'b1;
            wake_event <= 1'b0;
        end
        else
        begin
            wake_event <= 1'b0;
            if (operating && sleep_req)
                operating <= 1'b0;
            else if (!operating && (local_wake || wake_dom))
            begin
                operating  <= 1'b1;
                wake_event <= 1'b1;
            end
        end
    end

    // ********************************************************
    // path routing
    // ********************************************************
    can_fault_pkg::path_mode_t tx_mode;
    can_fault_pkg::path_mode_t rx_mode;

    // transmit path; IV, VIII and X leave it differential
    always_comb
    begin
        if (ov_h || h_lost)
            tx_mode = can_fault_pkg::PATH_L_ONLY;
        else if (ov_l || l_lost || wires_short)
            tx_mode = can_fault_pkg::PATH_H_ONLY;
        else
            tx_mode = can_fault_pkg::PATH_DIFF;
    end

    // receive path; I, II, V, IX and X leave it differential
    always_comb
    begin
        if (ov_h || vdd_h)
            rx_mode = can_fault_pkg::PATH_L_ONLY;
        else if (ov_l || gnd_l || wires_short)
            rx_mode = can_fault_pkg::PATH_H_ONLY;
        else
            rx_mode = can_fault_pkg::PATH_DIFF;
    end

    // registered driver enables and receive data
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            path      <= '{1'b0, 1'b0, 1'b1, 1'b1};
            rx_data_n <= 1'b1;
        end
        else
        begin
            path.drive_h   <= operating && !tx_block && !tx_n
                              && tx_mode != can_fault_pkg::PATH_L_ONLY;
            path.drive_l   <= operating && !tx_block && !tx_n
                              && tx_mode != can_fault_pkg::PATH_H_ONLY;
            path.rx_diff   <= (rx_mode == can_fault_pkg::PATH_DIFF);
            path.rx_from_h <= (rx_mode != can_fault_pkg::PATH_L_ONLY);
            unique case (rx_mode)
                can_fault_pkg::PATH_DIFF:   rx_data_n <= !(comp.canh_dom || comp.canl_dom);
                can_fault_pkg::PATH_H_ONLY: rx_data_n <= !comp.canh_dom;
                can_fault_pkg::PATH_L_ONLY: rx_data_n <= !comp.canl_dom;
            endcase
        end
    end

    // ********************************************************
    // error record
    // ********************************************************
    logic [3:0] next_type;

    // priority encode the active fault
    always_comb
    begin
        next_type = can_fault_pkg::FT_NONE;
        if (tx_stuck)          next_type = can_fault_pkg::FT_X;
        else if (ov_h)         next_type = can_fault_pkg::FT_III;
        else if (ov_l)         next_type = can_fault_pkg::FT_VI;
        else if (vdd_h)        next_type = can_fault_pkg::FT_VIII;
        else if (gnd_l)        next_type = can_fault_pkg::FT_IV;
        else if (wires_short)  next_type = can_fault_pkg::FT_VII;
        else if (h_lost)
            next_type = comp.canh_dom ? can_fault_pkg::FT_I : can_fault_pkg::FT_V;
        else if (l_lost)
            next_type = comp.canl_dom ? can_fault_pkg::FT_II : can_fault_pkg::FT_IX;
    end

    // flag and type kept until cleared; a new fault wins over clear
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            err_flag <= 1'b0;
            err_type <= can_fault_pkg::FT_NONE;
        end
        else if (next_type != can_fault_pkg::FT_NONE)
        begin
            err_flag <= 1'b1;
            err_type <= next_type;
        end
        else if (err_clear)
        begin
            err_flag <= 1'b0;
            err_type <= can_fault_pkg::FT_NONE;
        end
    end
endmodule : can_bus_fault_manager

// File: src/can_fault_pkg.sv
// Operation
// - edge count difference above three flags wire interrupted or permanently recessive
// - canh overvoltage declared after 32 us of continuous condition
// - canl overvoltage declared after 32 us of continuous condition
// - canl low and differential below -3.25 V for 1.3 ms flags canl ground short
// - differential below -3.25 V for 1.3 ms flags wires shorted together
// - canh high and differential below -3.25 V for 2.5 ms flags canh supply short
// - transmit dominant longer than 1.3 ms disables transmission
// - faults IV, VIII keep differential transmit
// - faults I, II, V, IX keep differential receive
// - overvoltage faults transmit single wire on healthy line
// - overvoltage faults receive single wire from healthy line
// - permanently recessive faults move transmit to usable line
// - wires shorted together transmit on one line only
// - wires shorted together receive from one line
// - permanently dominant faults receive from one line
// - protocol dominant fault keeps receiving normally
// - any fault sets error flag and stores its type code
// - sleep exits on local wake or bus dominant
// - bus wake needs dominant of at least 22 us
// - three dominant to recessive edges again recover an interrupted wire
// - fail safe released once transmit goes recessive, about 4 us
package can_fault_pkg;

    localparam int CLK_HZ        = 10_000_000;
    localparam int OV_TIME_US    = 32;
    localparam int SHORT_TIME_NS = 1_300_000;
    localparam int VDD_TIME_NS   = 2_500_000;
    localparam int FAILTX_NS     = 1_300_000;
    localparam int WAKE_TIME_US  = 22;
    localparam int RECOV_TIME_US = 4;
    localparam int OV_CYC     = OV_TIME_US * (CLK_HZ / 1_000_000);
    localparam int SHORT_CYC  = SHORT_TIME_NS / (1_000_000_000 / CLK_HZ);
    localparam int VDD_CYC    = VDD_TIME_NS / (1_000_000_000 / CLK_HZ);
    localparam int FAILTX_CYC = FAILTX_NS / (1_000_000_000 / CLK_HZ);
    localparam int WAKE_CYC   = WAKE_TIME_US * (CLK_HZ / 1_000_000);
    localparam int RECOV_CYC  = RECOV_TIME_US * (CLK_HZ / 1_000_000);
    localparam int EDGE_LIMIT  = 3;
    localparam int EDGE_RECOV  = 3;

    // fault type codes, one to ten, zero for none
    localparam logic [3:0] FT_NONE = 4'h0;
    localparam logic [3:0] FT_I    = 4'h1;
    localparam logic [3:0] FT_II   = 4'h2;
    localparam logic [3:0] FT_III  = 4'h3;
    localparam logic [3:0] FT_IV   = 4'h4;
    localparam logic [3:0] FT_V    = 4'h5;
    localparam logic [3:0] FT_VI   = 4'h6;
    localparam logic [3:0] FT_VII  = 4'h7;
    localparam logic [3:0] FT_VIII = 4'h8;
    localparam logic [3:0] FT_IX   = 4'h9;
    localparam logic [3:0] FT_X    = 4'ha;

    // analog comparator outputs from the bus front end
    typedef struct packed {
        logic canh_dom;      // canh dominant level
        logic canl_dom;      // canl dominant level
        logic canh_ov;       // canh above 7.2 V
        logic canl_ov;       // canl above 7.2 V
        logic canl_low;      // canl below 3.1 V
        logic diff_neg;      // canh minus canl below -3.25 V
        logic canh_high;     // canh above 1.8 V
    } bus_comp_t;

    // driver and receiver path selection
    typedef struct packed {
        logic drive_h;       // canh driver enabled
        logic drive_l;       // canl driver enabled
        logic rx_diff;       // differential receiver selected
        logic rx_from_h;     // single wire receive from canh
    } path_sel_t;

    typedef enum logic [1:0] {
        PATH_DIFF,
        PATH_H_ONLY,
        PATH_L_ONLY
    } path_mode_t;

endpackage : can_fault_pkg

// File: src/persist_timer.sv
`timescale 1ns/1ps
// ************************************************************
// persistence timer
// ************************************************************
module persist_timer #(
    parameter int COUNT = 16
) (
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic cond,
    output logic      expired
);
    localparam int W = $clog2(COUNT + 1);
    logic [W-1:0] count;

    // count while the condition holds, restart when it drops
    always_ff @(posedge clock)
    begin
        if (sys_rst || !cond)
            count <= '0;
        else if (count != W'(COUNT))
            count <= count + W'(1);
    end

    assign expired = cond && (count == W'(COUNT));
endmodule : persist_timer
